// ===== shared/gcct_pkg.sv
// constants, register map and types shared by the gated capture/compare timer
package gcct_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [11:0] IDX_COUNT_HI = 12'hf00;
	localparam logic [11:0] IDX_COUNT_LO = 12'hf01;
	localparam logic [11:0] IDX_RELOAD_HI = 12'hf02;
	localparam logic [11:0] IDX_RELOAD_LO = 12'hf03;
	localparam logic [11:0] IDX_CAPT_HI = 12'hf04;
	localparam logic [11:0] IDX_CAPT_LO = 12'hf05;
	localparam logic [11:0] IDX_OUTCFG = 12'hf06;
	localparam logic [11:0] IDX_CTRL = 12'hf07;
	localparam logic [11:0] IDX_IRQ_STS = 12'hf10;
	localparam logic [11:0] IDX_IRQ_MASK = 12'hf11;
	localparam int ADDR_W = 14;

	// control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_POL_BIT = 6;
	localparam int CTRL_PRES_LSB = 3;
	localparam int CTRL_MODE_LSB = 0;
	localparam int OUTCFG_EN_BIT = 0;

	// interrupt status fields
	localparam int STS_GATE_BIT = 0;
	localparam int STS_RELOAD_BIT = 1;
	localparam int STS_CAPT_BIT = 2;
	localparam int STS_W = 3;

	// reset and restart values
	localparam logic [15:0] COUNT_RST = 16'h0001;
	localparam logic [15:0] RELOAD_RST = 16'hffff;
	localparam logic [15:0] CAPT_RST = 16'h0000;
	localparam logic [15:0] COUNT_RESTART = 16'h0001;
	localparam logic [7:0] CTRL_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		GCCT_MODE_GATED = 3'b000,
		GCCT_MODE_CAPCMP = 3'b001
	} gcct_mode_t;

endpackage

// ===== shared/gcct_pin_if.sv
// synchronised timer input level and its edges
`timescale 1ns/1ps
`default_nettype none
interface gcct_pin_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== rtl/gcct_pin_sync.sv
// two-flop synchroniser and edge detector for the timer input pin
`timescale 1ns/1ps
`default_nettype none
module gcct_pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_in,
	gcct_pin_if.src p
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// meta_q feeds sync_q only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign p.level = sync_q;
	assign p.rise = sync_q & ~prev_q;
	assign p.fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ===== rtl/gcct_prescaler.sv
// power-of-two prescaler producing one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
module gcct_prescaler #(
	parameter int PRES_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [PRES_W-1:0] pres,
	output logic tick
);
	localparam int DIV_W = (1 << PRES_W) - 1;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] mask;

	if (PRES_W < 1 || PRES_W > 4) begin : g_chk
		$error("gcct_prescaler: PRES_W must be 1 to 4");
	end

	assign mask = DIV_W'(({{DIV_W{1'b0}}, 1'b1} << pres) - 1'b1);
	assign tick = run && ((div_q & mask) == mask);

	// divider restarts whenever the timer is stopped
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/gcct_timer.sv
// gated and capture/compare 16-bit timer with an AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gcct_timer
	import gcct_pkg::*;
#(
	parameter int PRES_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_in,
	output logic timer_out,
	output logic timer_out_oe,
	output logic irq
);

	if (PRES_W != 3) begin : g_chk
		$error("gcct_timer: control layout holds a 3-bit prescale field");
	end

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [15:0] count_q, reload_q, capt_q;
	logic [7:0] reload_hold_q, count_lo_hold_q, ctrl_q;
	logic [STS_W-1:0] sts_q, mask_q;
	logic out_cfg_q, started_q, toggle_q;
	logic en, pol, gated, capcmp;
	logic [PRES_W-1:0] pres;
	logic [2:0] mode;

	assign en = ctrl_q[CTRL_EN_BIT];
	assign pol = ctrl_q[CTRL_POL_BIT];
	assign pres = ctrl_q[CTRL_PRES_LSB +: PRES_W];
	assign mode = ctrl_q[CTRL_MODE_LSB +: 3];
	assign gated = (mode == GCCT_MODE_GATED);
	assign capcmp = (mode == GCCT_MODE_CAPCMP);

	// ------------------------------------------------------------
	// input pin and prescaler
	// ------------------------------------------------------------
	gcct_pin_if pin ();

	gcct_pin_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(timer_in),
		.p(pin.src)
	);

	logic tick;

	gcct_prescaler #(
		.PRES_W(PRES_W)
	) u_pres (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(en),
		.pres(pres),
		.tick(tick)
	);

	logic in_active, qual_edge, deassert_edge;

	assign in_active = pol ? pin.level : ~pin.level;
	assign qual_edge = pol ? pin.rise : pin.fall;
	assign deassert_edge = pol ? pin.fall : pin.rise;

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	logic awrdy_q, wrdy_q, bvalid_q, wr_lane_q, do_wr, wr_hit;
	logic [1:0] bresp_q;
	logic [11:0] wr_idx_q;
	logic [7:0] wr_data_q;

	// both address and data held, response not yet issued
	assign do_wr = !awrdy_q && !wrdy_q && !bvalid_q;
	assign wr_hit = wr_idx_q inside {IDX_COUNT_HI, IDX_COUNT_LO, IDX_RELOAD_HI, IDX_RELOAD_LO,
		IDX_CAPT_HI, IDX_CAPT_LO, IDX_OUTCFG, IDX_CTRL, IDX_IRQ_STS, IDX_IRQ_MASK};

	logic wr_en;
	assign wr_en = do_wr && wr_hit && wr_lane_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awrdy_q <= 1'b1;
			wr_idx_q <= 12'h000;
		end else if (s_axi_awvalid && awrdy_q) begin
			awrdy_q <= 1'b0;
			wr_idx_q <= s_axi_awaddr[ADDR_W-1:2];
		end else if (bvalid_q && s_axi_bready) begin
			awrdy_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wrdy_q <= 1'b1;
			wr_data_q <= 8'h00;
			wr_lane_q <= 1'b0;
		end else if (s_axi_wvalid && wrdy_q) begin
			wrdy_q <= 1'b0;
			wr_data_q <= s_axi_wdata[7:0];
			wr_lane_q <= s_axi_wstrb[0];
		end else if (bvalid_q && s_axi_bready) begin
			wrdy_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	logic arrdy_q, rvalid_q, rd_take, rd_hit;
	logic [1:0] rresp_q;
	logic [7:0] rdata_q, rd_val;
	logic [11:0] rd_idx;

	assign rd_take = s_axi_arvalid && arrdy_q;
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];

	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			IDX_COUNT_HI: rd_val = count_q[15:8];
			IDX_COUNT_LO: rd_val = en ? count_lo_hold_q : count_q[7:0];
			IDX_RELOAD_HI: rd_val = reload_q[15:8];
			IDX_RELOAD_LO: rd_val = reload_q[7:0];
			IDX_CAPT_HI: rd_val = capt_q[15:8];
			IDX_CAPT_LO: rd_val = capt_q[7:0];
			IDX_OUTCFG: rd_val = {7'h00, out_cfg_q};
			IDX_CTRL: rd_val = ctrl_q;
			IDX_IRQ_STS: rd_val = {5'h00, sts_q};
			IDX_IRQ_MASK: rd_val = {5'h00, mask_q};
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arrdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 8'h00;
		end else if (rd_take) begin
			arrdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q <= rd_val;
		end else if (rvalid_q && s_axi_rready) begin
			arrdy_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// high byte read while enabled takes a snapshot so a later low read is coherent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_lo_hold_q <= COUNT_RST[7:0];
		end else if (rd_take && rd_idx == IDX_COUNT_HI && en) begin
			count_lo_hold_q <= count_q[7:0];
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			out_cfg_q <= 1'b0;
			mask_q <= '0;
		end else if (wr_en) begin
			if (wr_idx_q == IDX_CTRL) begin
				ctrl_q <= wr_data_q;
			end
			if (wr_idx_q == IDX_OUTCFG) begin
				out_cfg_q <= wr_data_q[OUTCFG_EN_BIT];
			end
			if (wr_idx_q == IDX_IRQ_MASK) begin
				mask_q <= wr_data_q[STS_W-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_q <= RELOAD_RST;
			reload_hold_q <= RELOAD_RST[15:8];
		end else if (wr_en && wr_idx_q == IDX_RELOAD_HI) begin
			reload_hold_q <= wr_data_q;
		end else if (wr_en && wr_idx_q == IDX_RELOAD_LO) begin
			reload_q <= {reload_hold_q, wr_data_q};
		end
	end

	// ------------------------------------------------------------
	// counting engine
	// ------------------------------------------------------------
	logic at_reload, ev_reload, ev_capt, ev_gate, first_edge;

	assign at_reload = (count_q == reload_q);
	assign first_edge = en && capcmp && !started_q && qual_edge;
	assign ev_capt = en && capcmp && started_q && qual_edge;
	assign ev_reload = en && tick && at_reload && !ev_capt
		&& ((gated && in_active) || (capcmp && started_q));
	assign ev_gate = en && gated && deassert_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn || !en || !capcmp) begin
			started_q <= 1'b0;
		end else if (first_edge) begin
			started_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= COUNT_RST;
		end else if (wr_en && wr_idx_q == IDX_COUNT_HI) begin
			count_q[15:8] <= wr_data_q;
		end else if (wr_en && wr_idx_q == IDX_COUNT_LO) begin
			count_q[7:0] <= wr_data_q;
		end else if (ev_capt || ev_reload) begin
			count_q <= COUNT_RESTART;
		end else if (en && tick && gated && in_active) begin
			count_q <= count_q + 1'b1;
		end else if (en && tick && capcmp && started_q) begin
			count_q <= count_q + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capt_q <= CAPT_RST;
		end else if (ev_capt) begin
			capt_q <= count_q;
		end else if (wr_en && wr_idx_q == IDX_CAPT_HI) begin
			capt_q[15:8] <= wr_data_q;
		end else if (wr_en && wr_idx_q == IDX_CAPT_LO) begin
			capt_q[7:0] <= wr_data_q;
		end
	end

	// ------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			toggle_q <= 1'b0;
		end else if (ev_reload && out_cfg_q) begin
			toggle_q <= ~toggle_q;
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [STS_W-1:0] sts_set;
	logic irq_q;

	assign sts_set = {ev_capt, ev_reload, ev_gate};

	// a read clears, but an event in the same cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q <= '0;
		end else if (rd_take && rd_idx == IDX_IRQ_STS) begin
			sts_q <= sts_set;
		end else begin
			sts_q <= sts_q | sts_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_q & mask_q);
		end
	end

	assign s_axi_awready = awrdy_q;
	assign s_axi_wready = wrdy_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = {24'h000000, rdata_q};
	assign timer_out = toggle_q;
	assign timer_out_oe = out_cfg_q;
	assign irq = irq_q;

endmodule
`default_nettype wire

// ===== bench/gcct_pin_model.sv
// far-side model that drives the timer input pin
`timescale 1ns/1ps
`default_nettype none
module gcct_pin_model (
	input wire logic aclk,
	input wire logic want,
	input wire logic [3:0] lag,
	output var logic timer_in
);
	logic [15:0] hist_q = 16'h0000;
	// ---------------------------------------------
	// delayed pin level
	// ---------------------------------------------
	// a nonzero lag models a slow source behind the pin
	always_ff @(posedge aclk) begin
		hist_q <= {hist_q[14:0], want};
	end
	assign timer_in = (lag == 4'h0) ? want : hist_q[lag - 4'h1];
endmodule
`default_nettype wire

// ===== bench/gcct_timer_properties.sv
// concurrent checks on the timer's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
module gcct_timer_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_out,
	input wire logic timer_out_oe,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data above the byte not zero");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_toggle_oe: assert property ($changed(timer_out) |-> timer_out_oe || $past(timer_out_oe))
		else $error("output pin moved while disabled");
	c_irq: cover property ($rose(irq));
	c_toggle: cover property ($changed(timer_out));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind gcct_timer gcct_timer_properties gcct_timer_properties_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_out, .timer_out_oe, .irq);
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench: registers over AXI4-Lite, gated and capture/compare runs
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
	import gcct_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic timer_in, timer_out, timer_out_oe, irq, want = 1'b0, slow = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [7:0] d, e;
	int mismatches = 0, cmp_count = 0, cyc = 0, n;
	gcct_timer gcct_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .timer_in, .timer_out, .timer_out_oe, .irq);
	gcct_pin_model gcct_pin_model_i (.aclk, .want, .lag, .timer_in);
	initial forever #20 aclk = ~aclk;
	// ---------------------------------------------
	// bus, wait and verdict tasks
	// ---------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// far longer than the whole sequence needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic wr(input logic [11:0] i, input logic [7:0] v);
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			// a slow master accepts the response only once it has seen it
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] i);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] i, input logic [7:0] x);
		rd(i);
		`CHK(d, x)
	endtask
	task automatic wirq();
		for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge aclk);
	endtask
	task automatic wtog();
		logic t;
		t = timer_out;
		for (n = 0; n < 500 && timer_out === t; n++) @(posedge aclk);
	endtask
	// ---------------------------------------------
	// tests
	// ---------------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(IDX_COUNT_HI, 8'h00);
		rc(IDX_COUNT_LO, 8'h01);
		rc(IDX_CAPT_LO, 8'h00);
		rc(12'hf08, 8'h00);
		`CHK(rsp, RESP_SLVERR)
		wr(12'hf08, 8'h5a);
		`CHK(rsp, RESP_SLVERR)
		wr(IDX_RELOAD_HI, 8'h00);
		rc(IDX_RELOAD_HI, 8'hff);
		// a late ready makes the responses stand for a cycle before they are taken
		slow = 1'b1;
		wr(IDX_RELOAD_LO, 8'h05);
		rc(IDX_RELOAD_HI, 8'h00);
		slow = 1'b0;
		rc(IDX_RELOAD_LO, 8'h05);
		$display("test registers done");
		wr(IDX_COUNT_LO, 8'h03);
		wr(IDX_OUTCFG, 8'h01);
		wr(IDX_IRQ_MASK, 8'h02);
		wr(IDX_CTRL, 8'hc8);
		repeat (20) @(posedge aclk);
		rc(IDX_COUNT_HI, 8'h00);
		rc(IDX_COUNT_LO, 8'h03);
		`CHK(irq, 1'b0)
		want <= 1'b1;
		wtog();
		wtog();
		`CHK(n, 10)
		`CHK(timer_out_oe, 1'b1)
		`CHK(irq, 1'b1)
		wr(IDX_IRQ_MASK, 8'h01);
		rd(IDX_IRQ_STS);
		`CHK(d[STS_RELOAD_BIT], 1'b1)
		want <= 1'b0;
		wirq();
		`CHK(irq, 1'b1)
		rd(IDX_IRQ_STS);
		`CHK(d[STS_GATE_BIT], 1'b1)
		rc(IDX_IRQ_STS, 8'h00);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_COUNT_LO, 8'h07);
		rc(IDX_COUNT_LO, 8'h07);
		$display("test gated done");
		lag <= 4'h2;
		wr(IDX_COUNT_LO, 8'h01);
		wr(IDX_RELOAD_LO, 8'h40);
		wr(IDX_IRQ_MASK, 8'h04);
		wr(IDX_CTRL, 8'h81);
		want <= 1'b1;
		repeat (10) @(posedge aclk);
		rc(IDX_COUNT_HI, 8'h00);
		rc(IDX_COUNT_LO, 8'h01);
		want <= 1'b0;
		repeat (20) @(posedge aclk);
		`CHK(irq, 1'b0)
		want <= 1'b1;
		repeat (4) @(posedge aclk);
		want <= 1'b0;
		wirq();
		`CHK(irq, 1'b1)
		rd(IDX_CAPT_LO);
		// start and capture edges share the pin latency, so 24 cycles apart
		`CHK(d inside {8'h18, 8'h19}, 1'b1)
		rc(IDX_IRQ_STS, 8'h04);
		rd(IDX_COUNT_HI);
		rd(IDX_COUNT_LO);
		e = d;
		repeat (6) @(posedge aclk);
		rc(IDX_COUNT_LO, e);
		wr(IDX_COUNT_LO, 8'h30);
		rd(IDX_COUNT_HI);
		rd(IDX_COUNT_LO);
		`CHK(d inside {[8'h30 : 8'h3a]}, 1'b1)
		wr(IDX_IRQ_MASK, 8'h02);
		wirq();
		rd(IDX_IRQ_STS);
		`CHK(d[STS_RELOAD_BIT], 1'b1)
		$display("test capture compare done");
		print_verdict();
	end
endmodule
`default_nettype wire
